// file: core/csr_map.vh
// Constants for the core status register block: field positions, reset values, register offsets
// Function
// - The status word is 24 bits and reports core state and arithmetic outcomes.
// - Three bytes: extended mode 23..16, mode 15..8, condition code 7..0.
// - Field positions are bit indices of the whole 24-bit word.
// - Whole word is pushed to the system stack on loop setup and subroutine jump.
// - Extended mode and mode bytes load on reset, exception, loop end, return, trap.
// - Extended mode byte is also written by any full-word destination instruction.
// - Reset clears extended mode byte except core priority, which resets to ones.
// - Mode byte updates on loop start and logical or move ops targeting it or word.
// - Reset sets interrupt mask bits 9 and 8 and clears other mode bits.
// - Condition codes update on arithmetic, parallel moves, logical ops and word writes.
// - A parallel move changes only scaling and limit flags, bits 7 and 6.
// - Reset clears all eight condition code bits.
// - Reserved bit 18 always reads zero.
// - Core priority bits 23..22 set core external priority; reset value binary 11.
// - With priority select 00, active DMA channel priority is compared with core priority.
// - Core priority above DMA priority makes the DMA wait for a free bus slot.
// - Core priority below DMA priority makes core accesses wait for a free slot.
// - Equal priorities rotate grants: program, X data, Y data, DMA, repeating.
`ifndef CSR_MAP_VH
`define CSR_MAP_VH

`define CSR_WORD_W 24
`define CSR_EXT_HI 23
`define CSR_EXT_LO 16
`define CSR_MODE_HI 15
`define CSR_MODE_LO 8
`define CSR_CC_HI 7
`define CSR_CC_LO 0
`define CSR_CP_HI 23
`define CSR_CP_LO 22
`define CSR_RSVD_BIT 18
`define CSR_SL_HI 7
`define CSR_SL_LO 6

`define CSR_EXT_RESET 8'hC0
`define CSR_MODE_RESET 8'h03
`define CSR_CC_RESET 8'h00
`define CSR_EXT_WMASK 8'hFB
`define CSR_SL_MASK 8'hC0

`define CSR_ADDR_W 4
`define CSR_OFS_WORD 4'h0
`define CSR_OFS_EXT 4'h1
`define CSR_OFS_MODE 4'h2
`define CSR_OFS_CC 4'h3
`define CSR_OFS_ARB 4'h4

`define CSR_CDP_DYNAMIC 2'h0
`define CSR_CDP_CORE_LT 2'h1
`define CSR_CDP_CORE_EQ 2'h2
`define CSR_CDP_CORE_GT 2'h3

`endif

// file: core/csr_bus_arbiter.v
// External bus arbiter between core requesters and the active DMA channel
`timescale 1ns/1ps
`include "csr_map.vh"

module csr_bus_arbiter (
  input wire clock,
  input wire rst_n,
  input wire [1:0] core_bus_priority,
  input wire [1:0] dma_channel_priority,
  input wire [1:0] core_dma_priority_select,
  input wire req_p,
  input wire req_x,
  input wire req_y,
  input wire req_dma,
  output reg [3:0] grant_reg
);

  // ==========================================================
  // Effective priorities
  reg [1:0] eff_core;
  reg [1:0] eff_dma;
  always @* begin
    eff_dma = dma_channel_priority;
    case (core_dma_priority_select)
      `CSR_CDP_DYNAMIC: eff_core = core_bus_priority;
      `CSR_CDP_CORE_LT: begin
        eff_core = 2'h0;
        eff_dma = 2'h1;
      end
      `CSR_CDP_CORE_EQ: begin
        eff_core = 2'h1;
        eff_dma = 2'h1;
      end
      default: begin
        eff_core = 2'h1;
        eff_dma = 2'h0;
      end
    endcase
  end

  // ==========================================================
  // Grant selection; one grant per cycle, bit order P,X,Y,DMA
  localparam TURN_P = 4'h1;
  localparam TURN_X = 4'h2;
  localparam TURN_Y = 4'h4;
  localparam TURN_D = 4'h8;

  reg [3:0] turn_reg;
  reg [3:0] turn_next;
  reg [3:0] grant_next;
  wire [3:0] reqs = {req_dma, req_y, req_x, req_p};
  wire core_req = req_p | req_x | req_y;

  function [3:0] csr_fixed_core;
    input [3:0] r;
    begin
      if (r[0])
        csr_fixed_core = TURN_P;
      else if (r[1])
        csr_fixed_core = TURN_X;
      else if (r[2])
        csr_fixed_core = TURN_Y;
      else
        csr_fixed_core = 4'h0;
    end
  endfunction

  // Rotating search from the current turn so no requester starves at equal priority
  function [3:0] csr_rotate;
    input [3:0] r;
    input [3:0] t;
    reg [7:0] dbl;
    reg [3:0] pick;
    integer i;
    integer k;
    begin
      dbl = {r, r};
      pick = 4'h0;
      k = 0;
      for (i = 0; i < 4; i = i + 1) begin
        if (t[i])
          k = i;
      end
      for (i = 3; i >= 0; i = i - 1) begin
        if (dbl[k + i])
          pick = 4'h1 << ((k + i) % 4);
      end
      csr_rotate = pick;
    end
  endfunction

  always @* begin
    grant_next = 4'h0;
    turn_next = turn_reg;
    if (eff_core > eff_dma) begin
      grant_next = core_req ? csr_fixed_core(reqs) : (req_dma ? TURN_D : 4'h0);
    end else if (eff_core < eff_dma) begin
      grant_next = req_dma ? TURN_D : csr_fixed_core(reqs);
    end else begin
      grant_next = csr_rotate(reqs, turn_reg);
      if (grant_next != 4'h0)
        turn_next = {grant_next[2:0], grant_next[3]};
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      grant_reg <= 4'h0;
      turn_reg <= TURN_P;
    end else begin
      grant_reg <= grant_next;
      turn_reg <= turn_next;
    end
  end

endmodule

// file: core/csr_status_word.v
// Core status word register bank with stack push and external bus arbitration
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`include "csr_map.vh"

module csr_status_word (
  input wire clock,
  input wire rst_n,
  input wire [`CSR_ADDR_W-1:0] reg_addr,
  input wire [23:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [23:0] reg_rdata_reg,
  input wire exception_load,
  input wire loop_end_load,
  input wire return_load,
  input wire trap_load,
  input wire [23:0] restore_word,
  input wire loop_start,
  input wire [7:0] loop_mode_value,
  input wire loop_forever,
  input wire subroutine_jump,
  input wire [1:0] logic_target,
  input wire logic_is_or,
  input wire [7:0] logic_immediate,
  input wire alu_update,
  input wire [7:0] alu_flags,
  input wire [7:0] alu_mask,
  input wire move_update,
  input wire [1:0] move_sl_flags,
  input wire [1:0] core_dma_priority_select,
  input wire [1:0] dma_channel_priority,
  input wire req_p,
  input wire req_x,
  input wire req_y,
  input wire req_dma,
  output reg [23:0] processor_status_word_reg,
  output reg stack_push_reg,
  output reg [23:0] stack_data_reg,
  output wire [3:0] bus_grant
);

  // ==========================================================
  // Byte state
  reg [7:0] ext_reg;
  reg [7:0] mode_reg;
  reg [7:0] cc_reg;
  reg [7:0] ext_next;
  reg [7:0] mode_next;
  reg [7:0] cc_next;

  localparam TGT_NONE = 2'h0;
  localparam TGT_MODE = 2'h1;
  localparam TGT_CC = 2'h2;
  localparam TGT_WORD = 2'h3;

  // Reserved bit forced low wherever the extended byte is loaded
  function [7:0] csr_ext_clean;
    input [7:0] v;
    begin
      csr_ext_clean = v & `CSR_EXT_WMASK;
    end
  endfunction

  function [7:0] csr_logic_op;
    input [7:0] cur;
    input [7:0] imm;
    input is_or;
    begin
      csr_logic_op = is_or ? (cur | imm) : (cur & imm);
    end
  endfunction

  function [23:0] csr_pack;
    input [7:0] e;
    input [7:0] m;
    input [7:0] c;
    begin
      csr_pack = {csr_ext_clean(e), m, c};
    end
  endfunction

  wire bus_word_wr = reg_write && (reg_addr == `CSR_OFS_WORD);
  wire bus_ext_wr = reg_write && (reg_addr == `CSR_OFS_EXT);
  wire bus_mode_wr = reg_write && (reg_addr == `CSR_OFS_MODE);
  wire bus_cc_wr = reg_write && (reg_addr == `CSR_OFS_CC);
  wire hw_restore = exception_load | loop_end_load | return_load | trap_load;

  // ==========================================================
  // Update priority: implicit flags first, then explicit writes override
  always @* begin
    ext_next = ext_reg;
    mode_next = mode_reg;
    cc_next = cc_reg;
    if (alu_update)
      cc_next = (cc_reg & ~alu_mask) | (alu_flags & alu_mask);
    if (move_update)
      cc_next = {move_sl_flags, cc_next[`CSR_SL_HI-2:0]};
    if (hw_restore) begin
      ext_next = restore_word[`CSR_EXT_HI:`CSR_EXT_LO];
      mode_next = restore_word[`CSR_MODE_HI:`CSR_MODE_LO];
      cc_next = restore_word[`CSR_CC_HI:`CSR_CC_LO];
    end
    if (loop_start) begin
      mode_next = loop_mode_value;
      if (loop_forever)
        ext_next = restore_word[`CSR_EXT_HI:`CSR_EXT_LO];
    end
    case (logic_target)
      TGT_MODE: mode_next = csr_logic_op(mode_reg, logic_immediate, logic_is_or);
      TGT_CC: cc_next = csr_logic_op(cc_reg, logic_immediate, logic_is_or);
      TGT_WORD: begin
        ext_next = csr_logic_op(ext_reg, logic_immediate, logic_is_or);
        mode_next = csr_logic_op(mode_reg, logic_immediate, logic_is_or);
        cc_next = csr_logic_op(cc_reg, logic_immediate, logic_is_or);
      end
      TGT_NONE: ;
      default: ;
    endcase
    // Software writes last so they win over every implicit update
    if (bus_word_wr) begin
      ext_next = reg_wdata[`CSR_EXT_HI:`CSR_EXT_LO];
      mode_next = reg_wdata[`CSR_MODE_HI:`CSR_MODE_LO];
      cc_next = reg_wdata[`CSR_CC_HI:`CSR_CC_LO];
    end
    if (bus_ext_wr)
      ext_next = reg_wdata[7:0];
    if (bus_mode_wr)
      mode_next = reg_wdata[7:0];
    if (bus_cc_wr)
      cc_next = reg_wdata[7:0];
    ext_next = csr_ext_clean(ext_next);
  end

  // ==========================================================
  // State registers
  always @(posedge clock) begin
    if (!rst_n) begin
      ext_reg <= `CSR_EXT_RESET;
      mode_reg <= `CSR_MODE_RESET;
      cc_reg <= `CSR_CC_RESET;
    end else begin
      ext_reg <= ext_next;
      mode_reg <= mode_next;
      cc_reg <= cc_next;
    end
  end

  // Published word is loaded from the next-state bytes, so it changes on the same edge as the state
  always @(posedge clock) begin
    if (!rst_n)
      processor_status_word_reg <= {`CSR_EXT_RESET, `CSR_MODE_RESET, `CSR_CC_RESET};
    else
      processor_status_word_reg <= csr_pack(ext_next, mode_next, cc_next);
  end

  // ==========================================================
  // Stack push: the word before the instruction's own update is saved
  always @(posedge clock) begin
    if (!rst_n) begin
      stack_push_reg <= 1'b0;
      stack_data_reg <= 24'h000000;
    end else begin
      stack_push_reg <= loop_start | subroutine_jump;
      if (loop_start | subroutine_jump)
        stack_data_reg <= csr_pack(ext_reg, mode_reg, cc_reg);
    end
  end

  // ==========================================================
  // Register read port; data stands in the cycle after the strobe only
  reg [23:0] rd_mux;
  wire [7:0] arb_view = {4'h0, core_dma_priority_select, dma_channel_priority};
  always @* begin
    case (reg_addr)
      `CSR_OFS_WORD: rd_mux = csr_pack(ext_reg, mode_reg, cc_reg);
      `CSR_OFS_EXT: rd_mux = {16'h0000, csr_ext_clean(ext_reg)};
      `CSR_OFS_MODE: rd_mux = {16'h0000, mode_reg};
      `CSR_OFS_CC: rd_mux = {16'h0000, cc_reg};
      `CSR_OFS_ARB: rd_mux = {12'h000, bus_grant, arb_view};
      default: rd_mux = 24'h000000;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n)
      reg_rdata_reg <= 24'h000000;
    else if (reg_read)
      reg_rdata_reg <= rd_mux;
    else
      reg_rdata_reg <= 24'h000000;
  end

  // ==========================================================
  // External bus arbitration
  csr_bus_arbiter u_arb (
    .clock(clock),
    .rst_n(rst_n),
    .core_bus_priority(ext_reg[`CSR_CP_HI-`CSR_EXT_LO:`CSR_CP_LO-`CSR_EXT_LO]),
    .dma_channel_priority(dma_channel_priority),
    .core_dma_priority_select(core_dma_priority_select),
    .req_p(req_p),
    .req_x(req_x),
    .req_y(req_y),
    .req_dma(req_dma),
    .grant_reg(bus_grant)
  );

endmodule

// file: dv/csr_props.sv
// Assertion checker for the core status word block
`timescale 1ns/1ps
`include "csr_map.vh"
module csr_props (
  input wire clock,
  input wire rst_n,
  input wire [`CSR_ADDR_W-1:0] reg_addr,
  input wire [23:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [23:0] reg_rdata_reg,
  input wire loop_start,
  input wire subroutine_jump,
  input wire [1:0] core_dma_priority_select,
  input wire req_p,
  input wire req_dma,
  input wire [23:0] processor_status_word_reg,
  input wire stack_push_reg,
  input wire [23:0] stack_data_reg,
  input wire [3:0] bus_grant
);
  wire [23:0] w = processor_status_word_reg;
  wire push = loop_start | subroutine_jump;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ========================================
  // Status word
  property p_rst; $rose(rst_n) |-> w == 24'hC00300; endproperty
  a_rst: assert property (p_rst) else $error("reset word wrong");
  property p_rsvd; w[18] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  // A bus write is last in the priority chain, so nothing may spoil it
  property p_wr; reg_write && reg_addr == `CSR_OFS_WORD |=> w == ($past(reg_wdata) & 24'hFBFFFF); endproperty
  a_wr: assert property (p_wr) else $error("word write lost");
  property p_rd; !reg_read |=> reg_rdata_reg == 24'h000000; endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
  // ========================================
  // Stack push
  property p_push; push |=> stack_push_reg && stack_data_reg == $past(w); endproperty
  a_push: assert property (p_push) else $error("push missing");
  property p_nopush; !push |=> !stack_push_reg; endproperty
  a_nopush: assert property (p_nopush) else $error("stray push");
  // ========================================
  // Arbitration
  property p_hot; $onehot0(bus_grant); endproperty
  a_hot: assert property (p_hot) else $error("several grants");
  property p_lt; core_dma_priority_select == `CSR_CDP_CORE_LT && req_dma |=> bus_grant == 4'h8; endproperty
  a_lt: assert property (p_lt) else $error("dma not first");
  property p_gt; core_dma_priority_select == `CSR_CDP_CORE_GT && req_p |=> bus_grant == 4'h1; endproperty
  a_gt: assert property (p_gt) else $error("core not first");
endmodule
bind csr_status_word csr_props u_props (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata_reg, .loop_start, .subroutine_jump, .core_dma_priority_select, .req_p, .req_dma,
  .processor_status_word_reg, .stack_push_reg, .stack_data_reg, .bus_grant);

// file: dv/csr_far_model.sv
// Far side model: core fetch paths and active DMA channel as bus requesters
`timescale 1ns/1ps
module csr_far_model (
  input wire clock,
  input wire rst_n,
  input wire [3:0] want,
  input wire slow,
  output reg [3:0] req
);
  // Slow mode lags every request change by one extra cycle
  reg [3:0] lag_reg;
  always @(posedge clock) begin
    if (!rst_n) begin
      lag_reg <= 4'h0;
      req <= 4'h0;
    end else begin
      lag_reg <= want;
      req <= slow ? lag_reg : want;
    end
  end
endmodule

// file: dv/tb.sv
// Self-checking bench for the core status word block
`timescale 1ns/1ps
`include "csr_map.vh"
module tb;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  reg logic_is_or = 1'b0;
  reg slow = 1'b0;
  reg loop_forever = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [3:0] want = 4'h0;
  reg [7:0] st = 8'h00;
  reg [23:0] reg_wdata = 24'h000000;
  reg [23:0] restore_word = 24'h000000;
  reg [7:0] loop_mode_value = 8'h00;
  reg [7:0] logic_immediate = 8'h00;
  reg [7:0] alu_flags = 8'h00;
  reg [7:0] alu_mask = 8'h00;
  reg [1:0] logic_target = 2'h0;
  reg [1:0] move_sl_flags = 2'h0;
  reg [1:0] core_dma_priority_select = 2'h0;
  reg [1:0] dma_channel_priority = 2'h0;
  reg [31:0] seed = 32'h77AB;
  wire [23:0] reg_rdata_reg;
  wire [23:0] processor_status_word_reg;
  wire [23:0] stack_data_reg;
  wire stack_push_reg;
  wire [3:0] bus_grant;
  wire [3:0] req;
  integer err_total = 0;
  integer checks = 0;
  integer i;
  always #4 clock = ~clock;
  csr_far_model u_csr_far_model (.clock, .rst_n, .want, .slow, .req);
  csr_status_word u_csr_status_word (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata_reg, .exception_load(st[0]), .loop_end_load(st[1]), .return_load(st[2]), .trap_load(st[3]),
    .restore_word, .loop_start(st[4]), .loop_mode_value, .loop_forever, .subroutine_jump(st[5]),
    .logic_target, .logic_is_or, .logic_immediate, .alu_update(st[6]), .alu_flags, .alu_mask,
    .move_update(st[7]), .move_sl_flags, .core_dma_priority_select, .dma_channel_priority,
    .req_p(req[0]), .req_x(req[1]), .req_y(req[2]), .req_dma(req[3]), .processor_status_word_reg,
    .stack_push_reg, .stack_data_reg, .bus_grant);
  // ========================================
  // Helpers
  function [31:0] lf(input [31:0] x);
    lf = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function [23:0] fix(input [23:0] v);
    fix = v & 24'hFBFFFF;
  endfunction
  task chk(input [23:0] got, input [23:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Strobes drop with a spare cycle so no signal is assigned twice in one step
  task cyc(input w, input [3:0] a, input [23:0] d, input [7:0] s);
    begin
      reg_write <= w;
      reg_addr <= a;
      reg_wdata <= d;
      st <= s;
      @(posedge clock);
      reg_write <= 1'b0;
      st <= 8'h00;
      @(posedge clock);
    end
  endtask
  task rd(input [3:0] a, input [23:0] e);
    begin
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 chk(reg_rdata_reg, e);
      if (a == `CSR_OFS_WORD) chk(processor_status_word_reg, e);
      @(posedge clock);
    end
  endtask
  task push(input [7:0] s, input [23:0] e);
    begin
      st <= s;
      @(posedge clock);
      st <= 8'h00;
      #1 chk({23'h0, stack_push_reg}, 24'h000001);
      chk(stack_data_reg, e);
      @(posedge clock);
    end
  endtask
  task arb(input [1:0] s, input [1:0] p, input sl, input [3:0] e);
    reg [3:0] g;
    integer n;
    begin
      want <= 4'h0;
      repeat (4) @(posedge clock);
      core_dma_priority_select <= s;
      dma_channel_priority <= p;
      slow <= sl;
      want <= 4'hF;
      n = 0;
      while (bus_grant == 4'h0 && n < 20) begin
        @(posedge clock);
        #1 n = n + 1;
      end
      g = bus_grant;
      chk({23'h0, |g}, 24'h000001);
      if (e != 4'h0) chk({20'h0, g}, {20'h0, e});
      else repeat (4) begin
        @(posedge clock);
        #1 chk({20'h0, bus_grant}, {20'h0, g[2:0], g[3]});
        g = {g[2:0], g[3]};
      end
      @(posedge clock);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // ========================================
  // Sequence
  initial begin
    #200000;
    err_total = err_total + 1;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(`CSR_OFS_WORD, 24'hC00300);
    rd(`CSR_OFS_EXT, 24'h0000C0);
    rd(`CSR_OFS_MODE, 24'h000003);
    rd(4'hF, 24'h000000);
    $display("test reset done");
    for (i = 0; i < 16; i = i + 1) begin
      seed = lf(seed);
      cyc(1'b1, `CSR_OFS_WORD, seed[23:0], 8'h00);
      rd(`CSR_OFS_WORD, fix(seed[23:0]));
    end
    cyc(1'b1, `CSR_OFS_WORD, 24'hFFFFFF, 8'h00);
    rd(`CSR_OFS_EXT, 24'h0000FB);
    cyc(1'b1, `CSR_OFS_MODE, 24'h00005A, 8'h00);
    rd(`CSR_OFS_WORD, 24'hFB5AFF);
    $display("test regs done");
    move_sl_flags <= 2'h1;
    alu_flags <= 8'hFF;
    cyc(1'b0, 4'h0, 24'h0, 8'h80);
    rd(`CSR_OFS_CC, 24'h00007F);
    alu_flags <= 8'h00;
    alu_mask <= 8'h0F;
    cyc(1'b0, 4'h0, 24'h0, 8'h40);
    rd(`CSR_OFS_CC, 24'h000070);
    alu_mask <= 8'hFF;
    cyc(1'b1, `CSR_OFS_CC, 24'h000012, 8'h40);
    rd(`CSR_OFS_CC, 24'h000012);
    logic_target <= 2'h1;
    logic_is_or <= 1'b1;
    logic_immediate <= 8'h81;
    cyc(1'b0, 4'h0, 24'h0, 8'h00);
    logic_target <= 2'h2;
    logic_is_or <= 1'b0;
    logic_immediate <= 8'h0F;
    cyc(1'b0, 4'h0, 24'h0, 8'h00);
    logic_target <= 2'h0;
    rd(`CSR_OFS_WORD, 24'hFBDB02);
    $display("test flags done");
    loop_mode_value <= 8'h44;
    push(8'h10, 24'hFBDB02);
    push(8'h20, 24'hFB4402);
    loop_forever <= 1'b1;
    loop_mode_value <= 8'h0C;
    restore_word <= 24'h250000;
    push(8'h10, 24'hFB4402);
    loop_forever <= 1'b0;
    rd(`CSR_OFS_WORD, 24'h210C02);
    $display("test stack done");
    for (i = 0; i < 4; i = i + 1) begin
      seed = lf(seed);
      restore_word <= seed[23:0];
      cyc(1'b0, 4'h0, 24'h0, 8'h01 << i);
      rd(`CSR_OFS_WORD, fix(seed[23:0]));
    end
    $display("test loads done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(`CSR_OFS_WORD, 24'hC00300);
    $display("test reset again done");
    cyc(1'b1, `CSR_OFS_WORD, 24'hC00000, 8'h00);
    arb(2'h1, 2'h0, 1'b0, 4'h8);
    arb(2'h3, 2'h3, 1'b1, 4'h1);
    arb(2'h0, 2'h1, 1'b0, 4'h1);
    arb(2'h0, 2'h3, 1'b1, 4'h0);
    arb(2'h2, 2'h0, 1'b0, 4'h0);
    want <= 4'h0;
    cyc(1'b1, `CSR_OFS_WORD, 24'h000000, 8'h00);
    arb(2'h0, 2'h2, 1'b0, 4'h8);
    $display("test arb done");
    end_sim;
  end
endmodule
